// >>> flash_ctrl_pkg.sv
package flash_ctrl_pkg;

    // ************************************************************
    // register offsets (byte addresses, one word each)
    // ************************************************************
    localparam logic [7:0] OFF_ADDR = 8'h00;
    localparam logic [7:0] OFF_DATA = 8'h04;
    localparam logic [7:0] OFF_CMD = 8'h08;
    localparam logic [7:0] OFF_STAT = 8'h0C;
    localparam logic [7:0] OFF_USEC = 8'h10;
    localparam logic [7:0] OFF_IEN = 8'h14;
    localparam logic [7:0] OFF_RIS = 8'h18;
    localparam logic [7:0] OFF_MIS = 8'h1C;
    localparam logic [7:0] OFF_ICLR = 8'h20;
    localparam logic [7:0] OFF_PSEL = 8'h24;
    localparam logic [7:0] OFF_PLVL = 8'h28;
    localparam logic [7:0] OFF_USER0 = 8'h2C;
    localparam logic [7:0] OFF_USER1 = 8'h30;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int CMD_PROG_BIT = 0;
    localparam int CMD_ERASE_BIT = 1;
    localparam int CMD_PSAVE_BIT = 2;
    localparam int CMD_USAVE_BIT = 3;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_FAIL_BIT = 1;
    localparam int INT_DONE_BIT = 0;
    localparam int INT_ACCESS_BIT = 1;
    localparam int ERASE_LSB = 10;
    localparam int PROT_LSB = 11;

    // ************************************************************
    // reset values and operation durations in microseconds
    // ************************************************************
    localparam logic [7:0] USEC_RESET = 8'hFA;
    localparam logic [1:0] IEN_RESET = 2'h0;
    localparam logic [15:0] PROG_TIME_US = 16'h0014;
    localparam logic [15:0] ERASE_TIME_US = 16'h0FA0;
    localparam logic [15:0] SAVE_TIME_US = 16'h0064;

    // larger value is stricter, so tightening is a plain compare
    typedef enum logic [1:0] {
        prot_full_access = 2'h0,
        prot_no_write = 2'h1,
        prot_fetch_only = 2'h2
    } prot_level_t;

    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_run = 2'b01,
        st_check = 2'b11
    } seq_state_t;

    typedef enum logic [1:0] {
        op_prog = 2'h0,
        op_erase = 2'h1,
        op_prot_save = 2'h2,
        op_user_save = 2'h3
    } op_t;

endpackage

// >>> usec_timer.sv
`timescale 1ns/1ps
module usec_timer
    import flash_ctrl_pkg::*;
#(
    parameter int CPU_W = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic start,
    input wire logic [CPU_W-1:0] clocks_per_microsecond,
    input wire logic [15:0] duration_us,
    output logic done
);

    logic running_reg;
    logic [CPU_W-1:0] sub_reg;
    logic [15:0] us_reg;
    logic done_reg;

    // a zero setting would never tick, so it counts as one
    wire logic sub_wrap = (sub_reg >= clocks_per_microsecond - CPU_W'(1))
                          || (clocks_per_microsecond == '0);
    wire logic last_us = (us_reg <= 16'h0001);

    assign done = done_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            running_reg <= 1'b0;
            sub_reg <= '0;
            us_reg <= '0;
            done_reg <= 1'b0;
        end else if (ce) begin
            done_reg <= 1'b0;
            if (start) begin
                running_reg <= 1'b1;
                sub_reg <= '0;
                us_reg <= duration_us;
            end else if (running_reg) begin
                sub_reg <= sub_wrap ? '0 : sub_reg + CPU_W'(1);
                if (sub_wrap) begin
                    us_reg <= us_reg - 16'h0001;
                    if (last_us) begin
                        running_reg <= 1'b0;
                        done_reg <= 1'b1;
                    end
                end
            end
        end
    end

endmodule

// >>> flash_program_protect_ctrl.sv
// Our own choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
// Overview of operation
// - a disabled interrupt source never reaches the interrupt output
// - raw flags and flags masked by enables are both readable
// - status holds a busy flag and a failure flag
// - a programming error reports a failure result
// - each 2 kB region holds one of three protection levels
// - read-only regions allow reads and fetches, refuse erase and program
// - fetch-only regions allow only fetches, refuse every data read
// - protection may only tighten, never loosen
// - a fetch-only region never changes level
// - uncommitted protection lasts only until the next reset
// - protection commit writes settings to nonvolatile storage for good
// - clocks per microsecond times program and erase, not reads
// - software reads back the clocks per microsecond value
// - two user words, 0 and 1, writable and readable
// - user commit stores both user words permanently
// - erase works on 1 kB blocks to all ones; programming clears bits
// - completion flag on finish, access flag on invalid access
// - software clear drops pending flags
module flash_program_protect_ctrl
    import flash_ctrl_pkg::*;
#(
    parameter int NUM_BLOCKS = 16,
    parameter int FLASH_AW = 15,
    parameter int CPU_W = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic irq,
    input wire logic acc_valid,
    input wire logic [FLASH_AW-1:0] acc_addr,
    input wire logic acc_fetch,
    output logic acc_deny,
    output logic [FLASH_AW-1:0] flash_addr,
    output logic [31:0] flash_wdata,
    output logic flash_prog,
    output logic flash_erase,
    input wire logic flash_fail,
    output logic nv_prot_wr,
    output logic nv_user_wr,
    output logic [2*NUM_BLOCKS-1:0] nv_prot_out,
    output logic [31:0] nv_user0_out,
    output logic [31:0] nv_user1_out,
    input wire logic [2*NUM_BLOCKS-1:0] nv_prot_in,
    input wire logic [31:0] nv_user0_in,
    input wire logic [31:0] nv_user1_in
);

    localparam int BW = (NUM_BLOCKS > 1) ? $clog2(NUM_BLOCKS) : 1;

    if (NUM_BLOCKS < 2 || FLASH_AW < PROT_LSB + BW || FLASH_AW > 32
        || CPU_W < 8 || CPU_W > 32) begin : g_param_check
        $error("flash_program_protect_ctrl: unsupported parameters");
    end

    // ************************************************************
    // state
    // ************************************************************
    logic dp_reg;
    logic dp_write_reg;
    logic [7:0] dp_addr_reg;
    logic hreadyout_reg;
    logic [31:0] hrdata_reg;
    logic load_reg;
    logic [FLASH_AW-1:0] addr_reg;
    logic [31:0] data_reg;
    logic [CPU_W-1:0] usec_reg;
    logic [1:0] ien_reg;
    logic [1:0] ris_reg;
    logic irq_reg;
    logic fail_reg;
    logic [BW-1:0] psel_reg;
    logic [2*NUM_BLOCKS-1:0] prot_reg;
    logic [2*NUM_BLOCKS-1:0] prot_next;
    logic [31:0] user0_reg;
    logic [31:0] user1_reg;
    logic acc_deny_reg;
    seq_state_t state_reg;
    logic [FLASH_AW-1:0] flash_addr_reg;
    logic [31:0] flash_wdata_reg;
    logic flash_prog_reg;
    logic flash_erase_reg;
    logic nv_prot_wr_reg;
    logic nv_user_wr_reg;
    logic timer_done;

    // ************************************************************
    // bus decode
    // ************************************************************
    wire logic take = hsel & htrans[1] & hready;
    wire logic busy = (state_reg != st_idle);
    // stall the data phase until any operation has finished
    wire logic do_access = dp_reg & ~busy & ~load_reg;
    wire logic wr = do_access & dp_write_reg;
    wire logic wr_addr = wr && (dp_addr_reg == OFF_ADDR);
    wire logic wr_data = wr && (dp_addr_reg == OFF_DATA);
    wire logic wr_cmd = wr && (dp_addr_reg == OFF_CMD);
    wire logic wr_usec = wr && (dp_addr_reg == OFF_USEC);
    wire logic wr_ien = wr && (dp_addr_reg == OFF_IEN);
    wire logic wr_iclr = wr && (dp_addr_reg == OFF_ICLR);
    wire logic wr_psel = wr && (dp_addr_reg == OFF_PSEL);
    wire logic wr_plvl = wr && (dp_addr_reg == OFF_PLVL);
    wire logic wr_user0 = wr && (dp_addr_reg == OFF_USER0);
    wire logic wr_user1 = wr && (dp_addr_reg == OFF_USER1);

    // ************************************************************
    // protection lookup
    // ************************************************************
    wire logic [BW-1:0] op_blk = addr_reg[PROT_LSB +: BW];
    wire logic op_blk_ok = (FLASH_AW'(op_blk) == (addr_reg >> PROT_LSB))
                           && (int'(op_blk) < NUM_BLOCKS);
    wire logic [1:0] op_lvl = prot_reg[op_blk*2 +: 2];
    wire logic [1:0] sel_lvl = prot_reg[psel_reg*2 +: 2];
    wire logic [1:0] acc_lvl = prot_reg[acc_addr[PROT_LSB +: BW]*2 +: 2];
    wire logic acc_bad = acc_valid & ~acc_fetch
                         & (acc_lvl == prot_fetch_only);
    wire logic [1:0] req_lvl = hwdata[1:0];
    // only a strictly stricter, defined level is taken
    wire logic plvl_ok = (req_lvl > sel_lvl) && (req_lvl <= prot_fetch_only)
                         && (sel_lvl != prot_fetch_only);

    // ************************************************************
    // command decode
    // ************************************************************
    wire logic c_prog = wr_cmd & hwdata[CMD_PROG_BIT];
    wire logic c_erase = wr_cmd & ~hwdata[CMD_PROG_BIT] & hwdata[CMD_ERASE_BIT];
    wire logic c_psave = wr_cmd & ~(|hwdata[CMD_ERASE_BIT:CMD_PROG_BIT]) & hwdata[CMD_PSAVE_BIT];
    wire logic c_usave = wr_cmd & ~(|hwdata[CMD_PSAVE_BIT:CMD_PROG_BIT]) & hwdata[CMD_USAVE_BIT];
    wire logic misaligned = c_prog & (addr_reg[1:0] != 2'b00);
    wire logic array_op = c_prog | c_erase;
    // read-only and fetch-only blocks refuse writes to the array
    wire logic refuse = array_op & (misaligned | ~op_blk_ok
                        | (op_lvl != prot_full_access));
    wire logic start_op = (array_op & ~refuse) | c_psave | c_usave;
    wire logic [15:0] op_time = c_prog ? PROG_TIME_US : c_erase ? ERASE_TIME_US : SAVE_TIME_US;
    wire logic set_done = (state_reg == st_check);
    wire logic set_access = acc_bad | refuse;
    wire logic [1:0] clr = wr_iclr ? hwdata[1:0] : 2'b00;
    // a new event outlives a clear in the same cycle
    wire logic [1:0] ris_next = (ris_reg & ~clr) | {set_access, set_done};
    wire logic [1:0] ien_next = wr_ien ? hwdata[1:0] : ien_reg;
    wire logic [1:0] mis = ris_reg & ien_reg;

    // ************************************************************
    // read mux and protection update
    // ************************************************************
    wire logic [31:0] rdata =
        (dp_addr_reg == OFF_ADDR) ? 32'(addr_reg) :
        (dp_addr_reg == OFF_DATA) ? data_reg :
        (dp_addr_reg == OFF_STAT) ? {30'h0, fail_reg, busy} :
        (dp_addr_reg == OFF_USEC) ? 32'(usec_reg) :
        (dp_addr_reg == OFF_IEN) ? {30'h0, ien_reg} :
        (dp_addr_reg == OFF_RIS) ? {30'h0, ris_reg} :
        (dp_addr_reg == OFF_MIS) ? {30'h0, mis} :
        (dp_addr_reg == OFF_PSEL) ? 32'(psel_reg) :
        (dp_addr_reg == OFF_PLVL) ? {30'h0, sel_lvl} :
        (dp_addr_reg == OFF_USER0) ? user0_reg :
        (dp_addr_reg == OFF_USER1) ? user1_reg : 32'h0000_0000;

    for (genvar b = 0; b < NUM_BLOCKS; b++) begin : g_blk
        // reset forgets uncommitted changes; committed copy reloads
        assign prot_next[b*2 +: 2] =
            load_reg ? nv_prot_in[b*2 +: 2] :
            (wr_plvl && plvl_ok && (int'(psel_reg) == b)) ? req_lvl :
            prot_reg[b*2 +: 2];
    end

    assign hreadyout = hreadyout_reg;
    assign hresp = 1'b0;
    assign hrdata = hrdata_reg;
    assign irq = irq_reg;
    assign acc_deny = acc_deny_reg;
    assign flash_addr = flash_addr_reg;
    assign flash_wdata = flash_wdata_reg;
    assign flash_prog = flash_prog_reg;
    assign flash_erase = flash_erase_reg;
    assign nv_prot_wr = nv_prot_wr_reg;
    assign nv_user_wr = nv_user_wr_reg;
    assign nv_prot_out = prot_reg;
    assign nv_user0_out = user0_reg;
    assign nv_user1_out = user1_reg;

    usec_timer #(.CPU_W(CPU_W)) u_timer (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .start(start_op),
        .clocks_per_microsecond(usec_reg),
        .duration_us(op_time),
        .done(timer_done)
    );

    // ************************************************************
    // bus slave
    // ************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_reg <= 1'b0;
            dp_write_reg <= 1'b0;
            dp_addr_reg <= 8'h00;
            hreadyout_reg <= 1'b1;
            hrdata_reg <= 32'h0000_0000;
        end else if (ce) begin
            if (take) begin
                dp_reg <= 1'b1;
                dp_write_reg <= hwrite;
                dp_addr_reg <= {haddr[7:2], 2'b00};
                hreadyout_reg <= 1'b0;
            end else if (do_access) begin
                dp_reg <= 1'b0;
                hreadyout_reg <= 1'b1;
                hrdata_reg <= dp_write_reg ? 32'h0000_0000 : rdata;
            end
        end
    end

    // ************************************************************
    // software registers and flags
    // ************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            load_reg <= 1'b1;
            addr_reg <= '0;
            data_reg <= 32'h0000_0000;
            usec_reg <= CPU_W'(USEC_RESET);
            ien_reg <= IEN_RESET;
            ris_reg <= 2'b00;
            irq_reg <= 1'b0;
            psel_reg <= '0;
            prot_reg <= '0;
            user0_reg <= 32'h0000_0000;
            user1_reg <= 32'h0000_0000;
            acc_deny_reg <= 1'b0;
        end else if (ce) begin
            load_reg <= 1'b0;
            prot_reg <= prot_next;
            ris_reg <= ris_next;
            ien_reg <= ien_next;
            irq_reg <= |(ris_next & ien_next);
            acc_deny_reg <= acc_bad;
            if (load_reg) begin
                user0_reg <= nv_user0_in;
                user1_reg <= nv_user1_in;
            end
            if (wr_addr) begin
                addr_reg <= hwdata[FLASH_AW-1:0];
            end
            if (wr_data) begin
                data_reg <= hwdata;
            end
            if (wr_usec) begin
                usec_reg <= hwdata[CPU_W-1:0];
            end
            if (wr_psel) begin
                psel_reg <= hwdata[BW-1:0];
            end
            if (wr_user0) begin
                user0_reg <= hwdata;
            end
            if (wr_user1) begin
                user1_reg <= hwdata;
            end
        end
    end

    // ************************************************************
    // operation sequencer
    // ************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= st_idle;
            fail_reg <= 1'b0;
            flash_addr_reg <= '0;
            flash_wdata_reg <= 32'h0000_0000;
            flash_prog_reg <= 1'b0;
            flash_erase_reg <= 1'b0;
            nv_prot_wr_reg <= 1'b0;
            nv_user_wr_reg <= 1'b0;
        end else if (ce) begin
            if (wr_plvl) begin
                fail_reg <= ~plvl_ok;
            end
            case (state_reg)
                st_idle: begin
                    if (refuse) begin
                        fail_reg <= 1'b1;
                    end else if (start_op) begin
                        state_reg <= st_run;
                        flash_wdata_reg <= data_reg;
                        flash_prog_reg <= c_prog;
                        flash_erase_reg <= c_erase;
                        nv_prot_wr_reg <= c_psave;
                        nv_user_wr_reg <= c_usave;
                        // erase always covers the whole aligned block
                        flash_addr_reg <= c_erase ?
                            (addr_reg >> ERASE_LSB) << ERASE_LSB : addr_reg;
                    end
                end
                st_run: begin
                    if (timer_done) begin
                        state_reg <= st_check;
                    end
                end
                st_check: begin
                    // the array reports its result while the strobe still stands
                    fail_reg <= flash_fail;
                    flash_prog_reg <= 1'b0;
                    flash_erase_reg <= 1'b0;
                    nv_prot_wr_reg <= 1'b0;
                    nv_user_wr_reg <= 1'b0;
                    state_reg <= st_idle;
                end
                default: begin
                    state_reg <= st_idle;
                end
            endcase
        end
    end

endmodule

// >>> flash_checker_assertions.sv
`timescale 1ns/1ps
module flash_checker
    import flash_ctrl_pkg::*;
#(
    parameter int FLASH_AW = 15
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hreadyout,
    input wire logic acc_valid,
    input wire logic acc_fetch,
    input wire logic acc_deny,
    input wire logic [FLASH_AW-1:0] flash_addr,
    input wire logic [31:0] flash_wdata,
    input wire logic flash_prog,
    input wire logic flash_erase,
    input wire logic nv_prot_wr,
    input wire logic nv_user_wr
);
    // ******************
    // operation length
    // ******************
    // wide enough for the slowest clock setting
    wire logic op_busy = flash_prog | flash_erase | nv_prot_wr | nv_user_wr;
    logic [31:0] op_cnt_reg;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            op_cnt_reg <= 32'h0;
        end else if (ce) begin
            op_cnt_reg <= op_busy ? op_cnt_reg + 32'h1 : 32'h0;
        end
    end
    // ******************
    // properties
    // ******************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_fetch_ok; acc_valid && acc_fetch && ce |=> !acc_deny; endproperty
    a_fetch_ok: assert property (p_fetch_ok) else $error("fetch was denied");
    property p_idle_ok; !acc_valid && ce |=> !acc_deny; endproperty
    a_idle_ok: assert property (p_idle_ok) else $error("deny without access");
    property p_onehot; $onehot0({flash_prog, flash_erase, nv_prot_wr, nv_user_wr}); endproperty
    a_onehot: assert property (p_onehot) else $error("two operations at once");
    property p_stall; op_busy && !hreadyout |=> !hreadyout; endproperty
    a_stall: assert property (p_stall) else $error("bus released while busy");
    property p_stand;
        flash_prog |=> !flash_prog || ($stable(flash_addr) && $stable(flash_wdata));
    endproperty
    a_stand: assert property (p_stand) else $error("program target moved");
    property p_prog_align; flash_prog |-> flash_addr[1:0] == 2'h0; endproperty
    a_prog_align: assert property (p_prog_align) else $error("unaligned program");
    property p_erase_align; flash_erase |-> flash_addr[9:0] == 10'h000; endproperty
    a_erase_align: assert property (p_erase_align) else $error("unaligned erase");
    property p_prog_len; $fell(flash_prog) |-> op_cnt_reg >= PROG_TIME_US; endproperty
    a_prog_len: assert property (p_prog_len) else $error("program too short");
    property p_erase_len; $fell(flash_erase) |-> op_cnt_reg >= ERASE_TIME_US; endproperty
    a_erase_len: assert property (p_erase_len) else $error("erase too short");
    property p_save_len;
        $fell(nv_prot_wr) || $fell(nv_user_wr) |-> op_cnt_reg >= SAVE_TIME_US;
    endproperty
    a_save_len: assert property (p_save_len) else $error("commit too short");
    c_prog: cover property ($fell(flash_prog));
    c_user: cover property ($fell(nv_user_wr));
    c_deny: cover property (acc_deny);
endmodule

bind flash_program_protect_ctrl flash_checker #(.FLASH_AW(FLASH_AW)) u_chk (
    .hclk, .hresetn, .ce, .hreadyout, .acc_valid, .acc_fetch, .acc_deny, .flash_addr,
    .flash_wdata, .flash_prog, .flash_erase, .nv_prot_wr, .nv_user_wr
);

// >>> flash_far_model.sv
`timescale 1ns/1ps
module flash_far_model #(
    parameter int NUM_BLOCKS = 16
) (
    input wire logic hclk,
    input wire logic flash_prog,
    input wire logic flash_erase,
    input wire logic fail_en,
    output logic flash_fail,
    input wire logic nv_prot_wr,
    input wire logic nv_user_wr,
    input wire logic [2*NUM_BLOCKS-1:0] nv_prot_out,
    input wire logic [31:0] nv_user0_out,
    input wire logic [31:0] nv_user1_out,
    output logic [2*NUM_BLOCKS-1:0] nv_prot_in,
    output logic [31:0] nv_user0_in,
    output logic [31:0] nv_user1_in
);
    // ******************
    // nonvolatile store
    // ******************
    // no reset: the stored copy outlives every reset
    initial nv_prot_in = '0;
    initial nv_user0_in = 32'hFFFFFFFF;
    initial nv_user1_in = 32'hFFFFFFFF;
    always @(posedge hclk) begin
        if (nv_prot_wr) begin
            nv_prot_in <= nv_prot_out;
        end
        if (nv_user_wr) begin
            nv_user0_in <= nv_user0_out;
            nv_user1_in <= nv_user1_out;
        end
    end
    // commits report a result too; inverted outside operations to expose stray sampling
    assign flash_fail = !fail_en ^ (flash_prog | flash_erase | nv_prot_wr | nv_user_wr);
endmodule

// >>> flash_program_protect_ctrl_test.sv
`timescale 1ns/1ps
module flash_program_protect_ctrl_test
    import flash_ctrl_pkg::*;
;
    localparam int LIMIT = 20000;
    logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, rd_phase = 1'h0;
    logic fail_en = 1'h0, acc_valid = 1'h0, acc_fetch = 1'h0;
    logic hreadyout, hresp, irq, acc_deny, flash_prog, flash_erase, flash_fail;
    logic nv_prot_wr, nv_user_wr;
    logic [1:0] htrans = 2'h0;
    logic [14:0] acc_addr = 15'h0, flash_addr;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, u0, u1, r;
    logic [31:0] hrdata, flash_wdata, nv_prot_out, nv_prot_in;
    logic [31:0] nv_user0_out, nv_user1_out, nv_user0_in, nv_user1_in;
    logic [31:0] exp_q[$];
    string name_q[$];
    int errors, num_checks, cycles;
    flash_program_protect_ctrl dut (
        .hclk, .hresetn, .ce(1'h1), .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .irq, .acc_valid, .acc_addr,
        .acc_fetch, .acc_deny, .flash_addr, .flash_wdata, .flash_prog, .flash_erase,
        .flash_fail, .nv_prot_wr, .nv_user_wr, .nv_prot_out, .nv_user0_out, .nv_user1_out,
        .nv_prot_in, .nv_user0_in, .nv_user1_in
    );
    flash_far_model far (
        .hclk, .flash_prog, .flash_erase, .fail_en, .flash_fail, .nv_prot_wr, .nv_user_wr,
        .nv_prot_out, .nv_user0_out, .nv_user1_out, .nv_prot_in, .nv_user0_in, .nv_user1_in
    );
    always #2 hclk = ~hclk;
    // ******************
    // tasks
    // ******************
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] e);
        num_checks++;
        if (seen !== e) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", nm, e, seen);
        end
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // registered ready: its negedge value holds at the next edge
    task automatic ready_edge;
        @(negedge hclk);
        while (hreadyout !== 1'h1) @(negedge hclk);
        @(posedge hclk);
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'h1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        ready_edge();
        htrans <= 2'h0;
        hwdata <= d;
        rd_phase <= !w;
        ready_edge();
        rd_phase <= 1'h0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'h1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        exp_q.push_back(e);
        name_q.push_back(nm);
        xfer(1'h0, a, 32'h0);
    endtask
    task automatic op_chk(input logic [3:0] s);
        @(negedge hclk);
        check("strobes", 32'({nv_user_wr, nv_prot_wr, flash_erase, flash_prog}), 32'(s));
        @(posedge hclk);
    endtask
    task automatic deny_chk(input logic f, input logic [14:0] a, input logic e);
        acc_valid <= 1'h1;
        acc_fetch <= f;
        acc_addr <= a;
        @(posedge hclk);
        acc_valid <= 1'h0;
        @(negedge hclk);
        check("acc_deny", 32'(acc_deny), 32'(e));
        @(posedge hclk);
    endtask
    task automatic do_reset(input int n);
        hresetn <= 1'h0;
        repeat (n) @(posedge hclk);
        hresetn <= 1'h1;
        repeat (2) @(posedge hclk);
    endtask
    // ******************
    // result watcher
    // ******************
    always @(posedge hclk) begin
        cycles++;
        if (cycles == LIMIT) begin
            errors++;
            test_done();
        end else if (rd_phase && hreadyout && exp_q.size() > 0) begin
            check(name_q.pop_front(), hrdata, exp_q.pop_front());
            check("hresp", 32'(hresp), 32'h0);
        end
    end
    // ******************
    // sequence
    // ******************
    initial begin
        void'($urandom(84291));
        u0 = $urandom();
        u1 = $urandom();
        r = $urandom();
        do_reset(10);
        rd(OFF_USEC, {24'h0, USEC_RESET}, "usec");
        rd(OFF_IEN, {30'h0, IEN_RESET}, "ien");
        rd(OFF_PLVL, 32'h0, "plvl");
        rd(8'h40, 32'h0, "unmapped");
        wr(OFF_USEC, 32'h1);
        rd(OFF_USEC, 32'h1, "usec");
        wr(OFF_IEN, 32'h3);
        wr(OFF_ADDR, 32'h10);
        wr(OFF_DATA, r);
        wr(OFF_CMD, 32'h1);
        op_chk(4'h1);
        check("flash_addr", {17'h0, flash_addr}, 32'h10);
        check("flash_wdata", flash_wdata, r);
        rd(OFF_RIS, 32'h1, "ris");
        rd(OFF_STAT, 32'h0, "stat");
        rd(OFF_MIS, 32'h1, "mis");
        check("irq", {31'h0, irq}, 32'h1);
        wr(OFF_IEN, 32'h2);
        rd(OFF_MIS, 32'h0, "mis");
        check("irq", {31'h0, irq}, 32'h0);
        rd(OFF_RIS, 32'h1, "ris");
        wr(OFF_ICLR, 32'h1);
        rd(OFF_RIS, 32'h0, "ris");
        wr(OFF_IEN, 32'h3);
        fail_en <= 1'h1;
        wr(OFF_ADDR, 32'h20);
        wr(OFF_CMD, 32'h1);
        rd(OFF_STAT, 32'h2, "stat");
        fail_en <= 1'h0;
        wr(OFF_ADDR, 32'h7FC);
        wr(OFF_CMD, 32'h2);
        op_chk(4'h2);
        check("erase_addr", {17'h0, flash_addr}, 32'h400);
        rd(OFF_RIS, 32'h1, "ris");
        wr(OFF_PSEL, 32'h3);
        wr(OFF_PLVL, 32'h1);
        wr(OFF_PLVL, 32'h0);
        rd(OFF_PLVL, 32'h1, "plvl");
        rd(OFF_STAT, 32'h2, "stat");
        wr(OFF_PLVL, 32'h2);
        for (int v = 0; v < 2; v++) begin
            wr(OFF_PLVL, v);
            rd(OFF_PLVL, 32'h2, "plvl");
        end
        wr(OFF_ICLR, 32'h3);
        wr(OFF_ADDR, 32'h1800);
        for (int c = 1; c < 3; c++) begin
            wr(OFF_CMD, c);
            rd(OFF_RIS, 32'h2, "ris");
        end
        wr(OFF_ICLR, 32'h2);
        wr(OFF_ADDR, 32'h2);
        wr(OFF_CMD, 32'h1);
        rd(OFF_RIS, 32'h2, "ris");
        check("irq", {31'h0, irq}, 32'h1);
        deny_chk(1'h1, 15'h1804, 1'h0);
        deny_chk(1'h0, 15'h1804, 1'h1);
        deny_chk(1'h0, 15'h2004, 1'h0);
        wr(OFF_PSEL, 32'h1);
        wr(OFF_PLVL, 32'h1);
        deny_chk(1'h0, 15'h0800, 1'h0);
        wr(OFF_CMD, 32'h4);
        op_chk(4'h4);
        wr(OFF_PSEL, 32'h5);
        wr(OFF_PLVL, 32'h1);
        wr(OFF_USER0, u0);
        wr(OFF_USER1, u1);
        rd(OFF_USER0, u0, "user0");
        rd(OFF_USER1, u1, "user1");
        wr(OFF_CMD, 32'h8);
        op_chk(4'h8);
        rd(OFF_STAT, 32'h0, "stat");
        do_reset(3);
        wr(OFF_PSEL, 32'h3);
        rd(OFF_PLVL, 32'h2, "plvl");
        wr(OFF_PSEL, 32'h5);
        rd(OFF_PLVL, 32'h0, "plvl");
        rd(OFF_USER0, u0, "user0");
        rd(OFF_USER1, u1, "user1");
        test_done();
    end
endmodule
